//--- inc/fsc_regs.vh
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

// Register indices; byte address is four times the index
`define FSC_IDX_MBO_START 16'h0800
`define FSC_IDX_MBO_LEN 16'h0802
`define FSC_IDX_MBO_CTRL 16'h0804
`define FSC_IDX_MBI_START 16'h0808
`define FSC_IDX_MBI_LEN 16'h080A
`define FSC_IDX_MBI_CTRL 16'h080C
`define FSC_IDX_PD2_START 16'h0810
`define FSC_IDX_PD2_LEN 16'h0812
`define FSC_IDX_PD3_START 16'h0818
`define FSC_IDX_PD3_LEN 16'h081A
`define FSC_IDX_CLK_ACT 16'h0981
`define FSC_IDX_REQ 16'h0F00
`define FSC_IDX_STATE 16'h0F01
`define FSC_IDX_CODE 16'h0F02
`define FSC_IDX_ALARM 16'h0F03
`define FSC_IDX_MASK 16'h0F04
`define FSC_IDX_WDOG 16'h0F05
`define FSC_IDX_SYNC_OUT 16'h1C32
`define FSC_IDX_SYNC_IN 16'h1C33

// Slave states
`define FSC_ST_INIT 4'h1
`define FSC_ST_PREOP 4'h2
`define FSC_ST_BOOT 4'h3
`define FSC_ST_SAFEOP 4'h4
`define FSC_ST_OP 4'h8

// Status codes
`define FSC_CODE_NONE 16'h0000
`define FSC_CODE_MBOX 16'h0016
`define FSC_CODE_WDOG 16'h001F
`define FSC_CODE_CLK 16'h0030
`define FSC_CODE_EVENT 16'h0028

// Alarm bit positions
`define FSC_ALM_MBOX 1
`define FSC_ALM_WDOG 4
`define FSC_ALM_CLK 5
`define FSC_ALM_EVENT 6

// Check limits and codes
`define FSC_MBX_MIN_LEN 16'h0020
`define FSC_MBX_RAM_BASE 16'h1000
`define FSC_MBO_CTRL_CODE 4'h6
`define FSC_MBI_CTRL_CODE 4'h2
`define FSC_CLK_ACT_OFF 3'h0
`define FSC_CLK_ACT_SYNC0 3'h3
`define FSC_SYNC_FREE 8'h00
`define FSC_SYNC_OUT_SM2 8'h01
`define FSC_SYNC_CLK 8'h02
`define FSC_SYNC_IN_SM2 8'h22

// Timing
`define FSC_CLK_HZ 20000000
`define FSC_BLINK_HALF_MS 200

`endif

//--- core/fsc_checker.v
`include "fsc_regs.vh"
`default_nettype none

module fsc_checker (
  input wire [15:0] mbo_start,
  input wire [15:0] mbo_len,
  input wire [7:0] mbo_ctrl,
  input wire [15:0] mbi_start,
  input wire [15:0] mbi_len,
  input wire [7:0] mbi_ctrl,
  input wire [15:0] pd2_start,
  input wire [15:0] pd2_len,
  input wire [15:0] pd3_start,
  input wire [15:0] pd3_len,
  input wire [7:0] clk_act,
  input wire [7:0] sync_out,
  input wire [7:0] sync_in,
  input wire [15:0] wdog_time,
  output wire mbox_err,
  output wire wdog_err,
  output wire clk_err,
  output wire event_err
);

  // Two buffer ranges share at least one byte; empty ranges never clash
  function overlap;
    input [15:0] s1;
    input [15:0] l1;
    input [15:0] s2;
    input [15:0] l2;
    begin
      overlap = (l1 != 16'h0000) && (l2 != 16'h0000) &&
        ({1'b0, s1} < ({1'b0, s2} + {1'b0, l2})) &&
        ({1'b0, s2} < ({1'b0, s1} + {1'b0, l1}));
    end
  endfunction

  // Start must sit in buffer RAM and the range must not wrap past the top
  function bad_start;
    input [15:0] s;
    input [15:0] l;
    begin
      bad_start = (s < `FSC_MBX_RAM_BASE) ||
        (({1'b0, s} + {1'b0, l}) > 17'h10000);
    end
  endfunction

  wire start_bad;
  wire overlap_bad;
  wire odd_bad;
  wire len_bad;
  wire ctrl_bad;
  wire out_sm2;
  wire in_sm2;
  wire out_ok;
  wire in_ok;

  assign start_bad = bad_start(mbo_start, mbo_len) | bad_start(mbi_start, mbi_len);
  assign overlap_bad = overlap(mbo_start, mbo_len, mbi_start, mbi_len) |
    overlap(mbo_start, mbo_len, pd2_start, pd2_len) |
    overlap(mbo_start, mbo_len, pd3_start, pd3_len) |
    overlap(mbi_start, mbi_len, pd2_start, pd2_len) |
    overlap(mbi_start, mbi_len, pd3_start, pd3_len);
  assign odd_bad = mbo_start[0] | mbi_start[0];
  assign len_bad = (mbo_len < `FSC_MBX_MIN_LEN) |
    (mbi_len < `FSC_MBX_MIN_LEN);
  assign ctrl_bad = (mbo_ctrl[3:0] != `FSC_MBO_CTRL_CODE) |
    (mbi_ctrl[3:0] != `FSC_MBI_CTRL_CODE);
  assign mbox_err = start_bad | overlap_bad | odd_bad | len_bad | ctrl_bad;

  // A zero timeout would leave the process-data watchdog unable to fire
  assign wdog_err = (wdog_time == 16'h0000);

  assign clk_err = (clk_act[2:0] != `FSC_CLK_ACT_OFF) &&
    (clk_act[2:0] != `FSC_CLK_ACT_SYNC0);

  // Sync-mode objects
  assign out_sm2 = (sync_out == `FSC_SYNC_OUT_SM2);
  assign in_sm2 = (sync_in == `FSC_SYNC_IN_SM2);
  assign out_ok = (sync_out == `FSC_SYNC_FREE) || out_sm2 ||
    (sync_out == `FSC_SYNC_CLK);
  assign in_ok = (sync_in == `FSC_SYNC_FREE) || in_sm2 ||
    (sync_in == `FSC_SYNC_CLK);
  assign event_err = ~out_ok | ~in_ok |
    ((clk_act[2:0] == `FSC_CLK_ACT_OFF) && (out_sm2 != in_sm2));

endmodule // fsc_checker

`default_nettype wire

//--- core/fsc_top.v
`include "fsc_regs.vh"
`default_nettype none

module fsc_top #(
  parameter integer BLINK_HALF_CYCLES = `FSC_BLINK_HALF_MS * (`FSC_CLK_HZ / 1000)
) (
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [15:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg [3:0] STATE,
  output reg [15:0] AL_CODE,
  output reg IRQ,
  output reg ERR_LED
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function [15:0] adr;
    input [15:0] idx;
    begin
      adr = {idx[13:0], 2'b00};
    end
  endfunction

  // True for any up, down or sideways step the slave may take; Init is always legal
  function legal;
    input [3:0] cur;
    input [3:0] req;
    begin
      case (cur)
        `FSC_ST_INIT: legal = (req == `FSC_ST_PREOP) || (req == `FSC_ST_BOOT);
        `FSC_ST_PREOP: legal = (req == `FSC_ST_SAFEOP) || (req == `FSC_ST_PREOP);
        `FSC_ST_SAFEOP: legal = (req == `FSC_ST_PREOP) || (req == `FSC_ST_SAFEOP) ||
          (req == `FSC_ST_OP);
        `FSC_ST_OP: legal = (req == `FSC_ST_PREOP) || (req == `FSC_ST_SAFEOP) ||
          (req == `FSC_ST_OP);
        `FSC_ST_BOOT: legal = (req == `FSC_ST_BOOT);
        default: legal = 1'b0;
      endcase
      if (req == `FSC_ST_INIT) begin
        legal = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg [15:0] mbo_start_reg;
  reg [15:0] mbo_len_reg;
  reg [7:0] mbo_ctrl_reg;
  reg [15:0] mbi_start_reg;
  reg [15:0] mbi_len_reg;
  reg [7:0] mbi_ctrl_reg;
  reg [15:0] pd2_start_reg;
  reg [15:0] pd2_len_reg;
  reg [15:0] pd3_start_reg;
  reg [15:0] pd3_len_reg;
  reg [7:0] clk_act_reg;
  reg [7:0] sync_out_reg;
  reg [7:0] sync_in_reg;
  reg [15:0] wdog_reg;
  reg [3:0] req_reg;
  reg [7:0] mask_reg;
  reg [7:0] alarm_reg;
  reg [7:0] alarm_next;
  reg [3:0] state_next;
  reg [15:0] code_next;
  reg [31:0] rdata_next;
  reg hit_next;
  reg [31:0] blink_cnt_reg;
  reg blink_tick;

  wire setup_phase;
  wire access_done;
  wire wr_en;
  wire rd_done;
  wire req_wr;
  wire mbox_err;
  wire wdog_err;
  wire clk_err;
  wire event_err;

  // APB phases; the slave answers in the first access cycle
  assign setup_phase = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & PREADY;
  assign wr_en = access_done & PWRITE & ~PSLVERR;
  assign rd_done = access_done & ~PWRITE & ~PSLVERR;
  assign req_wr = wr_en & (PADDR == adr(`FSC_IDX_REQ));

  fsc_checker u_checker (
    .mbo_start(mbo_start_reg),
    .mbo_len(mbo_len_reg),
    .mbo_ctrl(mbo_ctrl_reg),
    .mbi_start(mbi_start_reg),
    .mbi_len(mbi_len_reg),
    .mbi_ctrl(mbi_ctrl_reg),
    .pd2_start(pd2_start_reg),
    .pd2_len(pd2_len_reg),
    .pd3_start(pd3_start_reg),
    .pd3_len(pd3_len_reg),
    .clk_act(clk_act_reg),
    .sync_out(sync_out_reg),
    .sync_in(sync_in_reg),
    .wdog_time(wdog_reg),
    .mbox_err(mbox_err),
    .wdog_err(wdog_err),
    .clk_err(clk_err),
    .event_err(event_err)
  );

  // Software writes; fsc_checker flags sync objects that disagree on SM2 while the clock is off
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mbo_start_reg <= 16'h0000;
      mbo_len_reg <= 16'h0000;
      mbo_ctrl_reg <= 8'h00;
      mbi_start_reg <= 16'h0000;
      mbi_len_reg <= 16'h0000;
      mbi_ctrl_reg <= 8'h00;
      pd2_start_reg <= 16'h0000;
      pd2_len_reg <= 16'h0000;
      pd3_start_reg <= 16'h0000;
      pd3_len_reg <= 16'h0000;
      clk_act_reg <= 8'h00;
      sync_out_reg <= 8'h00;
      sync_in_reg <= 8'h00;
      wdog_reg <= 16'h0000;
      req_reg <= `FSC_ST_INIT;
      mask_reg <= 8'h00;
    end else if (wr_en) begin
      case (PADDR)
        adr(`FSC_IDX_MBO_START): mbo_start_reg <= PWDATA[15:0];
        adr(`FSC_IDX_MBO_LEN): mbo_len_reg <= PWDATA[15:0];
        adr(`FSC_IDX_MBO_CTRL): mbo_ctrl_reg <= PWDATA[7:0];
        adr(`FSC_IDX_MBI_START): mbi_start_reg <= PWDATA[15:0];
        adr(`FSC_IDX_MBI_LEN): mbi_len_reg <= PWDATA[15:0];
        adr(`FSC_IDX_MBI_CTRL): mbi_ctrl_reg <= PWDATA[7:0];
        adr(`FSC_IDX_PD2_START): pd2_start_reg <= PWDATA[15:0];
        adr(`FSC_IDX_PD2_LEN): pd2_len_reg <= PWDATA[15:0];
        adr(`FSC_IDX_PD3_START): pd3_start_reg <= PWDATA[15:0];
        adr(`FSC_IDX_PD3_LEN): pd3_len_reg <= PWDATA[15:0];
        adr(`FSC_IDX_CLK_ACT): clk_act_reg <= PWDATA[7:0];
        adr(`FSC_IDX_SYNC_OUT): sync_out_reg <= PWDATA[7:0];
        adr(`FSC_IDX_SYNC_IN): sync_in_reg <= PWDATA[7:0];
        adr(`FSC_IDX_WDOG): wdog_reg <= PWDATA[15:0];
        adr(`FSC_IDX_REQ): req_reg <= PWDATA[3:0];
        adr(`FSC_IDX_MASK): mask_reg <= PWDATA[7:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave state machine and checks

  // Request checks the mailbox first, the rest only on PreOP to SafeOP; mailbox also watched while up
  always @* begin
    state_next = STATE;
    code_next = AL_CODE;
    alarm_next = 8'h00;
    if (req_wr) begin
      if (!legal(STATE, PWDATA[3:0])) begin
        // Illegal step is ignored
        state_next = STATE;
      end else if (PWDATA[3:0] == `FSC_ST_INIT) begin
        state_next = `FSC_ST_INIT;
        code_next = `FSC_CODE_NONE;
      end else if (mbox_err) begin
        state_next = `FSC_ST_INIT;
        code_next = `FSC_CODE_MBOX;
        alarm_next[`FSC_ALM_MBOX] = 1'b1;
      end else if ((STATE == `FSC_ST_PREOP) && (PWDATA[3:0] == `FSC_ST_SAFEOP) &&
          (wdog_err | clk_err | event_err)) begin
        // Transition refused; every failing check latches its alarm
        state_next = `FSC_ST_PREOP;
        alarm_next[`FSC_ALM_WDOG] = wdog_err;
        alarm_next[`FSC_ALM_CLK] = clk_err;
        alarm_next[`FSC_ALM_EVENT] = event_err;
        if (wdog_err) begin
          code_next = `FSC_CODE_WDOG;
        end else if (clk_err) begin
          code_next = `FSC_CODE_CLK;
        end else begin
          code_next = `FSC_CODE_EVENT;
        end
      end else begin
        state_next = PWDATA[3:0];
        code_next = `FSC_CODE_NONE;
      end
    end else if ((STATE != `FSC_ST_INIT) && mbox_err) begin
      // Reconfiguring a live mailbox drops the slave at once
      state_next = `FSC_ST_INIT;
      code_next = `FSC_CODE_MBOX;
      alarm_next[`FSC_ALM_MBOX] = 1'b1;
    end
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STATE <= `FSC_ST_INIT;
      AL_CODE <= `FSC_CODE_NONE;
    end else begin
      STATE <= state_next;
      AL_CODE <= code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm status, interrupt

  // Read clears only the bits returned; a new alarm wins over the clear
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      alarm_reg <= 8'h00;
    end else if (rd_done && (PADDR == adr(`FSC_IDX_ALARM))) begin
      alarm_reg <= (alarm_reg & ~PRDATA[7:0]) | alarm_next;
    end else begin
      alarm_reg <= alarm_reg | alarm_next;
    end
  end

  // Interrupt follows the status register it is derived from
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else if (rd_done && (PADDR == adr(`FSC_IDX_ALARM))) begin
      IRQ <= |(((alarm_reg & ~PRDATA[7:0]) | alarm_next) & mask_reg);
    end else if (wr_en && (PADDR == adr(`FSC_IDX_MASK))) begin
      IRQ <= |((alarm_reg | alarm_next) & PWDATA[7:0]);
    end else begin
      IRQ <= |((alarm_reg | alarm_next) & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error indicator

  // Half-period divider; kept free running so the blink phase is steady
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blink_cnt_reg <= 32'h00000000;
      blink_tick <= 1'b0;
    end else if (blink_cnt_reg >= BLINK_HALF_CYCLES - 1) begin
      blink_cnt_reg <= 32'h00000000;
      blink_tick <= 1'b1;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
      blink_tick <= 1'b0;
    end
  end

  // Blinks while any alarm is latched, dark once all are cleared
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ERR_LED <= 1'b0;
    end else if (alarm_reg == 8'h00) begin
      ERR_LED <= 1'b0;
    end else if (blink_tick) begin
      ERR_LED <= ~ERR_LED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read path

  // Read data is sampled in setup so PRDATA is a plain flop
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    case (PADDR)
      adr(`FSC_IDX_MBO_START): rdata_next[15:0] = mbo_start_reg;
      adr(`FSC_IDX_MBO_LEN): rdata_next[15:0] = mbo_len_reg;
      adr(`FSC_IDX_MBO_CTRL): rdata_next[7:0] = mbo_ctrl_reg;
      adr(`FSC_IDX_MBI_START): rdata_next[15:0] = mbi_start_reg;
      adr(`FSC_IDX_MBI_LEN): rdata_next[15:0] = mbi_len_reg;
      adr(`FSC_IDX_MBI_CTRL): rdata_next[7:0] = mbi_ctrl_reg;
      adr(`FSC_IDX_PD2_START): rdata_next[15:0] = pd2_start_reg;
      adr(`FSC_IDX_PD2_LEN): rdata_next[15:0] = pd2_len_reg;
      adr(`FSC_IDX_PD3_START): rdata_next[15:0] = pd3_start_reg;
      adr(`FSC_IDX_PD3_LEN): rdata_next[15:0] = pd3_len_reg;
      adr(`FSC_IDX_CLK_ACT): rdata_next[7:0] = clk_act_reg;
      adr(`FSC_IDX_SYNC_OUT): rdata_next[7:0] = sync_out_reg;
      adr(`FSC_IDX_SYNC_IN): rdata_next[7:0] = sync_in_reg;
      adr(`FSC_IDX_WDOG): rdata_next[15:0] = wdog_reg;
      adr(`FSC_IDX_REQ): rdata_next[3:0] = req_reg;
      adr(`FSC_IDX_STATE): rdata_next[3:0] = STATE;
      adr(`FSC_IDX_CODE): rdata_next[15:0] = AL_CODE;
      adr(`FSC_IDX_ALARM): rdata_next[7:0] = alarm_reg;
      adr(`FSC_IDX_MASK): rdata_next[7:0] = mask_reg;
      default: hit_next = 1'b0;
    endcase
  end

  // Zero wait states: ready in the first access cycle only
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (setup_phase) begin
      PREADY <= 1'b1;
      PSLVERR <= ~hit_next;
      PRDATA <= PWRITE ? 32'h00000000 : rdata_next;
    end else if (access_done) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

endmodule // fsc_top

`default_nettype wire

//--- testbench/fsc_top_assertions.sv
`include "fsc_regs.vh"
`default_nettype none
module fsc_top_assertions #(
  parameter integer BLINK_HALF_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] STATE,
  input wire logic [15:0] AL_CODE,
  input wire logic IRQ,
  input wire logic ERR_LED
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_reg;
  wire acc = PSEL && PENABLE && PREADY && PWRITE;
  // Request write lands at the state request register, byte address 3C00h
  wire req_acc = acc && (PADDR == 16'h3C00);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Length of the current lit phase; a stuck blink counter shows as a long one
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      run_reg <= 0;
    else
      run_reg <= ERR_LED ? run_reg + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_READY_PULSE: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not a single pulse after setup");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  AST_MBOX_INIT: assert property (AL_CODE == `FSC_CODE_MBOX |-> STATE == `FSC_ST_INIT)
    else $error("mailbox code outside Init");
  AST_WDOG_PREOP: assert property (AL_CODE == `FSC_CODE_WDOG |-> STATE == `FSC_ST_PREOP)
    else $error("watchdog code outside PreOP");
  AST_CLK_PREOP: assert property (AL_CODE == `FSC_CODE_CLK |-> STATE == `FSC_ST_PREOP)
    else $error("clock code outside PreOP");
  AST_EVT_PREOP: assert property (AL_CODE == `FSC_CODE_EVENT |-> STATE == `FSC_ST_PREOP)
    else $error("event code outside PreOP");
  // A request moves state at its own edge; a config write drops a live slave one edge later
  AST_STATE_CAUSE: assert property (($changed(STATE) || $changed(AL_CODE)) |-> $past(req_acc) || $past(acc, 2))
    else $error("state or code moved without a causing write");
  AST_BLINK_HALF: assert property (ERR_LED |-> run_reg < BLINK_HALF_CYCLES)
    else $error("indicator lit too long");
  // Main scenarios reached
  COV_SAFEOP: cover property (STATE == `FSC_ST_SAFEOP);
  COV_EVENT: cover property (AL_CODE == `FSC_CODE_EVENT);
  COV_BLINK: cover property ($rose(ERR_LED));
  COV_SLVERR: cover property (PSLVERR);
endmodule // fsc_top_assertions
`default_nettype wire

//--- testbench/fsc_master_model.sv
`include "fsc_regs.vh"
`default_nettype none
module fsc_master_model (
  input wire logic clk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [15:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One transfer; no cycle limit here, the bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx[13:0], 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~wd; // Stale data must not look valid
  endtask
  // Both sync-mode objects always get the same value
  task automatic sync_both(input logic [7:0] v);
    logic [31:0] rd;
    logic err;
    xfer(1'h1, `FSC_IDX_SYNC_OUT, {24'h0, v}, rd, err);
    xfer(1'h1, `FSC_IDX_SYNC_IN, {24'h0, v}, rd, err);
  endtask
endmodule // fsc_master_model
`default_nettype wire

//--- testbench/fsc_top_tb.sv
`include "fsc_regs.vh"
`default_nettype none
module fsc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, led, err;
  logic [15:0] paddr, code;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] state;
  int fails, n_tests, cyc;
  int c[14];
  int base[14] = '{16'h1000, 16'h80, 16'h26, 16'h1080, 16'h80, 16'h22, 16'h1100, 16'h10,
    16'h1180, 16'h10, 16'h0, 16'h0, 16'h0, 16'h3E8};
  logic [15:0] ix[14] = '{`FSC_IDX_MBO_START, `FSC_IDX_MBO_LEN, `FSC_IDX_MBO_CTRL,
    `FSC_IDX_MBI_START, `FSC_IDX_MBI_LEN, `FSC_IDX_MBI_CTRL, `FSC_IDX_PD2_START,
    `FSC_IDX_PD2_LEN, `FSC_IDX_PD3_START, `FSC_IDX_PD3_LEN, `FSC_IDX_CLK_ACT,
    `FSC_IDX_SYNC_OUT, `FSC_IDX_SYNC_IN, `FSC_IDX_WDOG};
  // Field, value pairs; field -1 keeps the good set
  int mq[$] = '{-1, 0, 0, 16'h0FFE, 3, 16'hFFC0, 3, 16'h1040, 6, 16'h1010, 8, 16'h10A0,
    0, 16'h1001, 3, 16'h1081, 1, 16'h1F, 1, 16'h20, 4, 16'h1F, 2, 16'h16, 2, 16'h07,
    5, 16'h03, 10, 16'h1, 10, 16'h2, 10, 16'h4, 10, 16'h7, 10, 16'h3, 10, 16'h0B,
    11, 16'h3, 11, 16'h1, 11, 16'h2, 12, 16'h1, 12, 16'h22, 12, 16'h2, 13, 16'h0};

  fsc_top #(.BLINK_HALF_CYCLES(8)) dut_u (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STATE(state), .AL_CODE(code), .IRQ(irq),
    .ERR_LED(led));
  fsc_master_model mdl_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    mdl_u.xfer(1'h1, i, v, rd, err);
  endtask
  task automatic rdx(input logic [15:0] i);
    mdl_u.xfer(1'h0, i, 32'h0, rd, err);
  endtask
  // A request moves outputs at its own edge, a config write one edge later; look just past the next edge
  task automatic settle(input int st, input int cd);
    @(posedge clk);
    #1;
    chk("state", {28'h0, state}, st);
    chk("code", {16'h0, code}, cd);
  endtask
  task automatic req(input logic [3:0] t, input int st, input int cd);
    wr(`FSC_IDX_REQ, {28'h0, t});
    settle(st, cd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reference checks, written apart from the design
  function automatic bit ov(int a, int la, int b, int lb);
    return la > 0 && lb > 0 && a < b + lb && b < a + la;
  endfunction
  function automatic bit mbx_bad();
    bit b;
    b = (c[2] & 15) != 6 || (c[5] & 15) != 2 || c[1] < 32 || c[4] < 32;
    for (int k = 0; k < 6; k += 3)
      b |= c[k] < 16'h1000 || c[k] + c[k + 1] > 32'h10000 || c[k] % 2;
    b |= ov(c[0], c[1], c[3], c[4]) || ov(c[0], c[1], c[6], c[7]);
    b |= ov(c[0], c[1], c[8], c[9]) || ov(c[3], c[4], c[6], c[7]);
    return b | ov(c[3], c[4], c[8], c[9]);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Hang guard, ample for the sequence below
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    int f, v, a, alm;
    bit cw, ck, ce;
    rst = 1'h1;
    void'($urandom(34));
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    chk("reset state", {28'h0, state}, `FSC_ST_INIT);
    foreach (ix[k]) begin
      rdx(ix[k]);
      chk("reset reg", rd, 0);
    end
    rdx(16'h0F10);
    chk("unmapped", {31'h0, err}, 1);
    wr(`FSC_IDX_MASK, 32'h70);
    repeat (20) begin
      f = $urandom_range(13, 0);
      v = $urandom_range(16'hFFFF, 0);
      if (f == 2 || f == 5 || f inside {[10:12]})
        v &= 16'hFF;
      mq.push_back(f);
      mq.push_back(v);
    end
    while (mq.size() > 0) begin
      f = mq.pop_front();
      v = mq.pop_front();
      c = base;
      if (f >= 0)
        c[f] = v;
      req(`FSC_ST_INIT, 1, 0);
      chk("led", {31'h0, led}, 0);
      for (int k = 0; k < 14; k++)
        wr(ix[k], c[k]);
      alm = 2;
      if (mbx_bad())
        req(`FSC_ST_PREOP, 1, 16'h16);
      else begin
        req(`FSC_ST_PREOP, 2, 0);
        a = c[10] & 7;
        cw = c[13] == 0;
        ck = a != 0 && a != 3;
        ce = !(c[11] inside {0, 1, 2}) || !(c[12] inside {0, 2, 16'h22});
        ce |= a == 0 && ((c[11] == 1) != (c[12] == 16'h22));
        alm = cw * 16 + ck * 32 + ce * 64;
        req(`FSC_ST_SAFEOP, alm ? 2 : 4, cw ? 16'h1F : ck ? 16'h30 : ce ? 16'h28 : 0);
      end
      chk("irq", {31'h0, irq}, (alm & 16'h70) != 0);
      rdx(`FSC_IDX_ALARM);
      chk("alarm", rd, alm);
      rdx(`FSC_IDX_ALARM);
      chk("alarm cleared", rd, 0);
    end
    // Running slave drops to Init when the mailbox breaks
    c = base;
    req(`FSC_ST_INIT, 1, 0);
    for (int k = 0; k < 11; k++)
      wr(ix[k], c[k]);
    // Last loop pass may have left a random timeout behind
    wr(`FSC_IDX_WDOG, c[13]);
    mdl_u.sync_both(8'h02);
    req(`FSC_ST_PREOP, 2, 0);
    req(`FSC_ST_SAFEOP, 4, 0);
    req(`FSC_ST_OP, 8, 0);
    wr(`FSC_IDX_MBO_LEN, 32'h1F);
    settle(1, 16'h16);
    // Latched alarm blinks: once started, half of any 16 cycles are lit
    a = 0;
    repeat (8) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      #1;
      a += led;
    end
    chk("led blink", a, 8);
    req(`FSC_ST_BOOT, 1, 16'h16);
    wr(`FSC_IDX_MBO_LEN, 32'h80);
    req(`FSC_ST_BOOT, 3, 0);
    req(`FSC_ST_OP, 3, 0);
    print_verdict();
  end
endmodule // fsc_top_tb
bind fsc_top fsc_top_assertions #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .STATE(STATE), .AL_CODE(AL_CODE), .IRQ(IRQ), .ERR_LED(ERR_LED));
`default_nettype wire
